// ---- hw/salw_regs.vh ----
`ifndef SALW_REGS_VH
`define SALW_REGS_VH

// ==========================================================
// Register byte offsets
`define SALW_OFF_FEATURE   8'h00
`define SALW_OFF_COUNT     8'h04
`define SALW_OFF_ADDR_LOW  8'h08
`define SALW_OFF_ADDR_MID  8'h0c
`define SALW_OFF_ADDR_HIGH 8'h10
`define SALW_OFF_UNIT      8'h14
`define SALW_OFF_COMMAND   8'h18
`define SALW_OFF_STATUS    8'h1c
`define SALW_OFF_ERROR     8'h20
`define SALW_OFF_CONFIG    8'h24
`define SALW_OFF_DATA      8'h28
`define SALW_OFF_PEEK_ADDR 8'h2c
`define SALW_OFF_PEEK_DATA 8'h30
`define SALW_OFF_POWER     8'h34

// ==========================================================
// Status and error bit positions
`define SALW_ST_BSY   7
`define SALW_ST_DRDY  6
`define SALW_ST_DF    5
`define SALW_ST_DRQ   3
`define SALW_ST_ERR   0
`define SALW_ER_IDNF  4
`define SALW_ER_ABRT  2
`define SALW_UNIT_DEV 4

// ==========================================================
// Config bit positions and reset values
`define SALW_CFG_PM      0
`define SALW_CFG_LOGSUP  1
`define SALW_CFG_RELEN   2
`define SALW_CFG_DEVNUM  3
`define SALW_CFG_IDMISS  4
`define SALW_CFG_FAULT   5
`define SALW_CFG_RST     8'h07
`define SALW_STATUS_RST  8'h40

// ==========================================================
// Command codes and required inputs
`define SALW_CMD_LOG     8'hb0
`define SALW_CMD_STBY    8'he2
`define SALW_CMD_STBYI   8'he0
`define SALW_FEAT_WRLOG  8'hd6
`define SALW_KEY_MID     8'h4f
`define SALW_KEY_HIGH    8'hc2
`define SALW_LOG_MAX_SEC 8'h01
`define SALW_WORDS_SEC   7

// ==========================================================
// Standby timer: 5 s units, 10 MHz clock
`define SALW_UNIT_S      5
`define SALW_CLK_HZ      10000000
`define SALW_SHORT_MAX   8'hf0
`define SALW_LONG_UNITS  16'h02d0

`endif

// ---- hw/salw_stby_tmr.v ----
`timescale 1ns/100ps
`default_nettype none
`include "salw_regs.vh"

module salw_stby_tmr #(
  parameter TICK_CYCLES = `SALW_UNIT_S * `SALW_CLK_HZ
) (
  input  wire       clk,      // System clock
  input  wire       rst_n,    // Synchronous reset, low
  input  wire       load,     // Program timer from count
  input  wire [7:0] count,    // Period code
  input  wire       activity, // Host command seen
  output reg        expire    // One-cycle expiry pulse
);

  reg  [25:0] tick_cnt;
  reg  [15:0] remaining;
  reg  [7:0]  code;
  reg         enabled;
  wire        tick;

  // Codes beyond the short range share one long period
  function [15:0] period_units;
    input [7:0] c;
    begin
      if (c <= `SALW_SHORT_MAX) begin
        period_units = {8'h00, c};
      end else begin
        period_units = `SALW_LONG_UNITS;
      end
    end
  endfunction

  // Compared at 32 bits so a short simulation period needs no resizing
  localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

  assign tick = ({6'h00, tick_cnt} == TICK_LAST);

  always @(posedge clk) begin
    if (!rst_n) begin
      tick_cnt  <= 26'h0000000;
      remaining <= 16'h0000;
      code      <= 8'h00;
      enabled   <= 1'b0;
      expire    <= 1'b0;
    end else begin
      expire <= 1'b0;
      if (tick || load || activity) begin
        tick_cnt <= 26'h0000000;
      end else begin
        tick_cnt <= tick_cnt + 26'h0000001;
      end
      if (load) begin
        code      <= count;
        enabled   <= (count != 8'h00);
        remaining <= period_units(count);
      end else if (activity) begin
        remaining <= period_units(code);
      end else if (enabled && tick && remaining != 16'h0000) begin
        remaining <= remaining - 16'h0001;
        if (remaining == 16'h0001) begin
          expire <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- hw/salw_cmd.v ----
// Behaviour
// - Log write success clears BSY/DF/DRQ/ERR, sets DRDY
// - Abort log write on bad inputs
// - Read-only log target aborts command
// - Missing log sector ID sets IDNF
// - Unimplemented log address sets ABRT
// - Log write error clears DRQ, sets ERR
// - Log write stores count of 512-byte sectors
// - Standby command E2h enters Standby mode
// - Nonzero count enables and loads standby timer
// - Zero count disables standby timer
// - No power management aborts standby commands
// - Immediate standby E0h accepted, no data
// - Standby success clears BSY/DF/DRQ/ERR, sets DRDY
// - Standby error sets DRDY, DF on fault, ERR
// - Unperformable action may also set ABRT
// - Immediate standby ignores standby timer
`timescale 1ns/100ps
`default_nettype none
`include "salw_regs.vh"

module salw_cmd #(
  parameter TICK_CYCLES = `SALW_UNIT_S * `SALW_CLK_HZ
) (
  input  wire        SYS_CLK,       // 10 MHz clock
  input  wire        RST_N,         // Synchronous reset, low
  input  wire [7:0]  S_AXI_AWADDR,  // Write address
  input  wire        S_AXI_AWVALID, // Write address valid
  output reg         S_AXI_AWREADY, // Write address ready
  input  wire [31:0] S_AXI_WDATA,   // Write data
  input  wire [3:0]  S_AXI_WSTRB,   // Write byte strobes
  input  wire        S_AXI_WVALID,  // Write data valid
  output reg         S_AXI_WREADY,  // Write data ready
  output reg  [1:0]  S_AXI_BRESP,   // Write response
  output reg         S_AXI_BVALID,  // Write response valid
  input  wire        S_AXI_BREADY,  // Write response ready
  input  wire [7:0]  S_AXI_ARADDR,  // Read address
  input  wire        S_AXI_ARVALID, // Read address valid
  output reg         S_AXI_ARREADY, // Read address ready
  output reg  [31:0] S_AXI_RDATA,   // Read data
  output reg  [1:0]  S_AXI_RRESP,   // Read response
  output reg         S_AXI_RVALID,  // Read data valid
  input  wire        S_AXI_RREADY,  // Read data ready
  output reg         STANDBY_MODE   // Device in Standby
);

  // ==========================================================
  // State and storage
  localparam ST_IDLE = 2'b00;
  localparam ST_EVAL = 2'b01;
  localparam ST_XFER = 2'b10;
  localparam ST_DONE = 2'b11;
  localparam RESP_OK  = 2'b00;
  localparam RESP_ERR = 2'b10;

  reg  [7:0]  feature_param;
  reg  [7:0]  count_param;
  reg  [7:0]  start_address_low;
  reg  [7:0]  address_mid_byte;
  reg  [7:0]  address_high_byte;
  reg  [7:0]  unit_select;
  reg  [7:0]  command_code;
  reg  [7:0]  completion_flags;
  reg  [7:0]  failure_flags;
  reg  [7:0]  config_bits;
  reg  [8:0]  peek_addr;
  reg  [1:0]  state;
  reg  [15:0] words_left;
  reg  [8:0]  wr_ptr;
  reg  [31:0] log_mem [0:511];
  reg         aw_held;
  reg         w_held;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;
  reg         tmr_load;
  reg         tmr_activity;
  wire        tmr_expire;
  wire        do_wr;
  wire        lane0;
  wire        cmd_write;
  wire        data_write;
  wire        df_now;
  wire        log_bad;

  // ==========================================================
  // Decode helpers
  function reg_known;
    input [7:0] a;
    begin
      reg_known = (a[1:0] == 2'b00) && (a <= `SALW_OFF_POWER);
    end
  endfunction

  // 2: writable, 1: read-only, 0: not implemented
  function [1:0] log_class;
    input [7:0] a;
    begin
      if (a == 8'h00 || a == 8'h01) begin
        log_class = 2'd1;
      end else if (a >= 8'h80 && a <= 8'h83) begin
        log_class = 2'd2;
      end else begin
        log_class = 2'd0;
      end
    end
  endfunction

  assign do_wr      = aw_held && w_held && !S_AXI_BVALID;
  assign lane0      = w_strb[0];
  assign cmd_write  = do_wr && lane0 && (aw_addr == `SALW_OFF_COMMAND) &&
                      !completion_flags[`SALW_ST_BSY] && (state == ST_IDLE);
  assign data_write = do_wr && (w_strb == 4'hf) && (aw_addr == `SALW_OFF_DATA) &&
                      (state == ST_XFER);
  assign df_now     = config_bits[`SALW_CFG_FAULT];

  assign log_bad = !config_bits[`SALW_CFG_LOGSUP] ||
                   !config_bits[`SALW_CFG_RELEN] ||
                   (feature_param != `SALW_FEAT_WRLOG) ||
                   (address_mid_byte != `SALW_KEY_MID) ||
                   (address_high_byte != `SALW_KEY_HIGH) ||
                   (count_param == 8'h00) ||
                   (count_param > `SALW_LOG_MAX_SEC) ||
                   (log_class(start_address_low) != 2'd2);

  // ==========================================================
  // AXI4-Lite write channel: address and data taken in any order
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= RESP_OK;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held       <= 1'b1;
        aw_addr       <= S_AXI_AWADDR;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held       <= 1'b1;
        w_data       <= S_AXI_WDATA;
        w_strb       <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_wr) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= reg_known(aw_addr) ? RESP_OK : RESP_ERR;
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Host-written parameter registers
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      feature_param     <= 8'h00;
      count_param       <= 8'h00;
      start_address_low <= 8'h00;
      address_mid_byte  <= 8'h00;
      address_high_byte <= 8'h00;
      unit_select       <= 8'h00;
      command_code      <= 8'h00;
      config_bits       <= `SALW_CFG_RST;
      peek_addr         <= 9'h000;
    end else if (do_wr && lane0) begin
      case (aw_addr)
        `SALW_OFF_FEATURE:   feature_param     <= w_data[7:0];
        `SALW_OFF_COUNT:     count_param       <= w_data[7:0];
        `SALW_OFF_ADDR_LOW:  start_address_low <= w_data[7:0];
        `SALW_OFF_ADDR_MID:  address_mid_byte  <= w_data[7:0];
        `SALW_OFF_ADDR_HIGH: address_high_byte <= w_data[7:0];
        `SALW_OFF_UNIT:      unit_select       <= w_data[7:0];
        `SALW_OFF_CONFIG:    config_bits       <= w_data[7:0];
        `SALW_OFF_PEEK_ADDR: peek_addr         <= w_data[8:0];
        `SALW_OFF_COMMAND: begin
          if (cmd_write) begin
            command_code <= w_data[7:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // Log storage: one sector per writable log
  always @(posedge SYS_CLK) begin
    if (data_write) begin
      log_mem[wr_ptr] <= w_data;
    end
  end

  // ==========================================================
  // Command execution
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      state            <= ST_IDLE;
      completion_flags <= `SALW_STATUS_RST;
      failure_flags    <= 8'h00;
      words_left       <= 16'h0000;
      wr_ptr           <= 9'h000;
      tmr_load         <= 1'b0;
      tmr_activity     <= 1'b0;
      STANDBY_MODE     <= 1'b0;
    end else begin
      tmr_load     <= 1'b0;
      tmr_activity <= cmd_write;
      if (tmr_expire) begin
        STANDBY_MODE <= 1'b1;
      end
      case (state)
        ST_IDLE: begin
          // Commands for the other device on the cable are ignored
          if (cmd_write &&
              (unit_select[`SALW_UNIT_DEV] == config_bits[`SALW_CFG_DEVNUM])) begin
            completion_flags <= 8'h80;
            failure_flags    <= 8'h00;
            state            <= ST_EVAL;
          end
        end
        ST_EVAL: begin
          state <= ST_IDLE;
          case (command_code)
            `SALW_CMD_LOG: begin
              if (log_bad) begin
                failure_flags    <= 8'h04;
                completion_flags <= {1'b0, 1'b1, df_now, 4'h0, 1'b1};
              end else begin
                completion_flags <= 8'h48;
                words_left       <= {1'b0, count_param, 7'h00};
                wr_ptr           <= {start_address_low[1:0], 7'h00};
                STANDBY_MODE     <= 1'b0;
                state            <= ST_XFER;
              end
            end
            `SALW_CMD_STBY, `SALW_CMD_STBYI: begin
              if (!config_bits[`SALW_CFG_PM]) begin
                failure_flags    <= 8'h04;
                completion_flags <= {1'b0, 1'b1, df_now, 4'h0, 1'b1};
              end else begin
                completion_flags <= 8'h40;
                STANDBY_MODE     <= 1'b1;
                tmr_load         <= (command_code == `SALW_CMD_STBY);
              end
            end
            default: begin
              failure_flags    <= 8'h04;
              completion_flags <= {1'b0, 1'b1, df_now, 4'h0, 1'b1};
            end
          endcase
        end
        ST_XFER: begin
          if (data_write) begin
            wr_ptr     <= wr_ptr + 9'h001;
            words_left <= words_left - 16'h0001;
            if (words_left == 16'h0001) begin
              completion_flags <= 8'h80;
              state            <= ST_DONE;
            end
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
          if (config_bits[`SALW_CFG_IDMISS]) begin
            failure_flags    <= 8'h10;
            completion_flags <= {1'b0, 1'b1, df_now, 4'h0, 1'b1};
          end else begin
            failure_flags    <= 8'h00;
            completion_flags <= 8'h40;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always @(posedge SYS_CLK) begin
    if (!RST_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= RESP_OK;
    end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_ARREADY <= 1'b0;
        S_AXI_RVALID  <= 1'b1;
        S_AXI_RRESP   <= reg_known(S_AXI_ARADDR) ? RESP_OK : RESP_ERR;
        case (S_AXI_ARADDR)
          `SALW_OFF_COUNT:     S_AXI_RDATA <= {24'h000000, count_param};
          `SALW_OFF_ADDR_LOW:  S_AXI_RDATA <= {24'h000000, start_address_low};
          `SALW_OFF_ADDR_MID:  S_AXI_RDATA <= {24'h000000, address_mid_byte};
          `SALW_OFF_ADDR_HIGH: S_AXI_RDATA <= {24'h000000, address_high_byte};
          `SALW_OFF_UNIT:      S_AXI_RDATA <= {24'h000000, unit_select};
          `SALW_OFF_STATUS:    S_AXI_RDATA <= {24'h000000, completion_flags};
          `SALW_OFF_ERROR:     S_AXI_RDATA <= {24'h000000, failure_flags};
          `SALW_OFF_CONFIG:    S_AXI_RDATA <= {24'h000000, config_bits};
          `SALW_OFF_PEEK_ADDR: S_AXI_RDATA <= {23'h000000, peek_addr};
          `SALW_OFF_PEEK_DATA: S_AXI_RDATA <= log_mem[peek_addr];
          `SALW_OFF_POWER:     S_AXI_RDATA <= {31'h00000000, STANDBY_MODE};
          default:             S_AXI_RDATA <= 32'h00000000;
        endcase
      end
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Standby timer
  salw_stby_tmr #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tmr (
    .clk      (SYS_CLK),
    .rst_n    (RST_N),
    .load     (tmr_load),
    .count    (count_param),
    .activity (tmr_activity),
    .expire   (tmr_expire)
  );

endmodule
`default_nettype wire

// ---- bench/salw_monitor.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// Port checker
module salw_monitor (
  input wire logic        SYS_CLK,       // Clock
  input wire logic        RST_N,         // Reset, low
  input wire logic [7:0]  S_AXI_AWADDR,  // AW addr
  input wire logic        S_AXI_AWVALID, // AW valid
  input wire logic        S_AXI_AWREADY, // AW ready
  input wire logic [31:0] S_AXI_WDATA,   // W data
  input wire logic [3:0]  S_AXI_WSTRB,   // W strobes
  input wire logic        S_AXI_WVALID,  // W valid
  input wire logic        S_AXI_WREADY,  // W ready
  input wire logic [1:0]  S_AXI_BRESP,   // B resp
  input wire logic        S_AXI_BVALID,  // B valid
  input wire logic        S_AXI_BREADY,  // B ready
  input wire logic [7:0]  S_AXI_ARADDR,  // AR addr
  input wire logic        S_AXI_ARVALID, // AR valid
  input wire logic        S_AXI_ARREADY, // AR ready
  input wire logic [31:0] S_AXI_RDATA,   // R data
  input wire logic        S_AXI_RVALID,  // R valid
  input wire logic        S_AXI_RREADY,  // R ready
  input wire logic        STANDBY_MODE   // Standby
);
  logic wr_go;
  logic rd_st;
  logic stby_cmd;
  logic pm_on;
  logic dev_cfg;
  logic dev_sel;
  assign wr_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  assign rd_st = S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR == 8'h1c;
  assign stby_cmd = wr_go && S_AXI_AWADDR == 8'h18 && (S_AXI_WDATA[7:0] & 8'hfd) == 8'he0;
  // Shadow only the bits that decide whether a standby command may run
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      pm_on <= 1'b1;
      dev_cfg <= 1'b0;
      dev_sel <= 1'b0;
    end else if (wr_go && S_AXI_WSTRB[0] && S_AXI_AWADDR == 8'h24) begin
      pm_on <= S_AXI_WDATA[0];
      dev_cfg <= S_AXI_WDATA[3];
    end else if (wr_go && S_AXI_WSTRB[0] && S_AXI_AWADDR == 8'h14) begin
      dev_sel <= S_AXI_WDATA[4];
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped early");
  r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped early");
  rd_lat_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
    else $error("read answer late");
  wr_lat_a: assert property (wr_go |=> ##1 (S_AXI_BVALID && !S_AXI_AWREADY))
    else $error("write answer late");
  bad_addr_a: assert property (wr_go && (S_AXI_AWADDR > 8'h34 || S_AXI_AWADDR[1:0] != 2'b00)
    |=> ##1 (S_AXI_BRESP == 2'b10)) else $error("unmapped write not refused");
  idle_rst_a: assert property (disable iff (1'b0) !RST_N |=> !S_AXI_BVALID && !S_AXI_RVALID
    && !STANDBY_MODE && S_AXI_AWREADY && S_AXI_ARREADY) else $error("reset state wrong");
  stby_in_a: assert property (stby_cmd && pm_on && dev_sel == dev_cfg |=> ##2 STANDBY_MODE)
    else $error("standby not entered");
  stby_no_a: assert property (stby_cmd && !pm_on && !STANDBY_MODE |-> ##3 !STANDBY_MODE)
    else $error("standby entered without power management");
  st_flags_a: assert property (rd_st |=> (S_AXI_RDATA[7] || S_AXI_RDATA[6])
    && !(S_AXI_RDATA[3] && S_AXI_RDATA[0]) && S_AXI_RDATA[31:8] == 24'h0) else $error("status flags wrong");
  cover property (stby_cmd && pm_on);
  cover property (rd_st);
  cover property ($rose(STANDBY_MODE) && !$past(wr_go));
endmodule
bind salw_cmd salw_monitor salw_monitor_inst (.*);
`default_nettype wire

// ---- bench/salw_host.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========
// Host adapter model
module salw_host (
  input  wire logic        SYS_CLK,       // Clock
  output logic [7:0]  S_AXI_AWADDR,  // AW addr
  output logic        S_AXI_AWVALID, // AW valid
  input  wire logic        S_AXI_AWREADY, // AW ready
  output logic [31:0] S_AXI_WDATA,   // W data
  output logic [3:0]  S_AXI_WSTRB,   // W strobes
  output logic        S_AXI_WVALID,  // W valid
  input  wire logic        S_AXI_WREADY,  // W ready
  input  wire logic [1:0]  S_AXI_BRESP,   // B resp
  input  wire logic        S_AXI_BVALID,  // B valid
  output logic        S_AXI_BREADY,  // B ready
  output logic [7:0]  S_AXI_ARADDR,  // AR addr
  output logic        S_AXI_ARVALID, // AR valid
  input  wire logic        S_AXI_ARREADY, // AR ready
  input  wire logic [31:0] S_AXI_RDATA,   // R data
  input  wire logic [1:0]  S_AXI_RRESP,   // R resp
  input  wire logic        S_AXI_RVALID,  // R valid
  output logic        S_AXI_RREADY   // R ready
);
  // Response readies stay high so no task ever lowers one at a shared edge
  initial begin
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_ARVALID} = 3'b000;
    {S_AXI_BREADY, S_AXI_RREADY} = 2'b11;
    S_AXI_WSTRB = 4'hf;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA} = 48'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa;
    logic pw;
    pa = 1'b1;
    pw = 1'b1;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    while (pa || pw) begin
      @(posedge SYS_CLK);
      if (pa && S_AXI_AWREADY) begin
        pa = 1'b0;
        S_AXI_AWVALID <= 1'b0;
        S_AXI_AWADDR <= ~a;
      end
      if (pw && S_AXI_WREADY) begin
        pw = 1'b0;
        S_AXI_WVALID <= 1'b0;
        S_AXI_WDATA <= ~d;
      end
    end
    do @(posedge SYS_CLK); while (!S_AXI_BVALID);
    r = S_AXI_BRESP;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do @(posedge SYS_CLK); while (!S_AXI_ARREADY);
    S_AXI_ARVALID <= 1'b0;
    S_AXI_ARADDR <= ~a;
    do @(posedge SYS_CLK); while (!S_AXI_RVALID);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
  endtask
endmodule
`default_nettype wire

// ---- bench/test_standby_and_log_write_cmds.sv ----
`timescale 1ns/100ps
`default_nettype none
module test_standby_and_log_write_cmds;
  localparam int TICK = 10;
  logic        SYS_CLK = 1'b0;
  logic        RST_N = 1'b0;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, v, last_w;
  logic [39:0] lp;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
  logic        S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic        S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, STANDBY_MODE;
  int          n_errors = 0, samples_checked = 0, cyc = 0;
  logic [39:0] bad [8] = '{40'hd5_01_80_4f_c2, 40'hd6_00_80_4f_c2, 40'hd6_02_80_4f_c2, 40'hd6_01_00_4f_c2,
                           40'hd6_01_01_4f_c2, 40'hd6_01_90_4f_c2, 40'hd6_01_80_4e_c2, 40'hd6_01_80_4f_c3};
  always #50 SYS_CLK = ~SYS_CLK;
  salw_cmd #(.TICK_CYCLES(TICK)) salw_cmd_inst (.*);
  salw_host salw_host_inst (.*);
  // ==========
  // Checks and bus helpers
  task automatic complete_run;
    $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    salw_host_inst.rd(a, v, r);
    chk(nm, v, exp);
  endtask
  task automatic w8(input logic [7:0] a, input logic [7:0] d);
    salw_host_inst.wr(a, {24'h0, d}, r);
  endtask
  task automatic cmd(input logic [7:0] c);
    int k;
    k = 0;
    do begin
      salw_host_inst.rd(8'h1c, v, r);
      k++;
    end while ((v[7] || !v[6]) && k < 50);
    w8(8'h18, c);
    repeat (3) @(posedge SYS_CLK);
  endtask
  task automatic log_try(input logic [39:0] p);
    lp = p;
    for (int k = 0; k < 5; k++) w8(8'(4 * k), p[39 - 8 * k -: 8]);
    cmd(8'hb0);
  endtask
  task automatic sector;
    repeat (128) begin
      last_w = $urandom;
      salw_host_inst.wr(8'h28, last_w, r);
    end
  endtask
  // Error completion: DRDY and ERR, DF only for an injected fault
  function automatic logic [31:0] fail_st(input logic fault);
    return {24'h0, 2'b01, fault, 4'h0, 1'b1};
  endfunction
  function automatic logic [39:0] good;
    return {16'hd601, 6'h20, 2'($urandom), 16'h4fc2};
  endfunction
  function automatic int stby_cycles(input logic [7:0] c);
    return (c > 8'hf0 ? 720 : int'(c)) * TICK;
  endfunction
  // ==========
  // Tests
  initial begin
    int i;
    int t0;
    int per;
    logic [7:0] c;
    c = 8'($urandom(32'hb08c));
    repeat (12) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    @(posedge SYS_CLK);
    rchk(8'h1c, 32'h40, "status");
    rchk(8'h20, 32'h0, "error");
    rchk(8'h24, 32'h7, "config");
    rchk(8'h34, 32'h0, "power");
    for (i = 1; i < 6; i++) begin
      c = 8'($urandom);
      w8(8'(4 * i), c);
      rchk(8'(4 * i), {24'h0, c}, "rw register");
    end
    w8(8'h00, 8'hd6);
    rchk(8'h00, 32'h0, "write-only register");
    salw_host_inst.wr(8'h3c, 32'h1, r);
    chk("unmapped write", 32'(r), 32'h2);
    salw_host_inst.rd(8'h38, v, r);
    chk("unmapped read", 32'(r), 32'h2);
    $display("registers test done");
    w8(8'h14, 8'h00);
    for (i = 0; i < 2; i++) begin
      w8(8'h24, i ? 8'h26 : 8'h06);
      cmd(i ? 8'he2 : 8'he0);
      rchk(8'h1c, fail_st(i[0]), "status");
      rchk(8'h20, 32'h4, "error");
      chk("standby", 32'(STANDBY_MODE), 32'h0);
    end
    w8(8'h24, 8'h07);
    w8(8'h14, 8'h10);
    cmd(8'he0);
    rchk(8'h1c, fail_st(1'b1), "status");
    chk("standby", 32'(STANDBY_MODE), 32'h0);
    $display("power management absent test done");
    w8(8'h14, 8'h00);
    cmd(8'he0);
    rchk(8'h1c, 32'h40, "status");
    rchk(8'h20, 32'h0, "error");
    chk("standby", 32'(STANDBY_MODE), 32'h1);
    w8(8'h04, 8'h00);
    cmd(8'he2);
    rchk(8'h1c, 32'h40, "status");
    chk("standby", 32'(STANDBY_MODE), 32'h1);
    log_try(good());
    rchk(8'h1c, 32'h48, "status");
    sector();
    rchk(8'h1c, 32'h40, "status");
    rchk(8'h20, 32'h0, "error");
    // Last word of the sector sits at the top of the chosen log
    salw_host_inst.wr(8'h2c, {23'h0, lp[17:16], 7'h7f}, r);
    rchk(8'h30, last_w, "log word");
    repeat (100) @(posedge SYS_CLK);
    chk("standby", 32'(STANDBY_MODE), 32'h0);
    $display("standby test done");
    for (i = 0; i < 8; i++) begin
      log_try(bad[i]);
      rchk(8'h1c, fail_st(1'b0), "status");
      rchk(8'h20, 32'h4, "error");
    end
    cmd(8'h55);
    rchk(8'h1c, fail_st(1'b0), "status");
    rchk(8'h20, 32'h4, "error");
    w8(8'h24, 8'h23);
    log_try(good());
    rchk(8'h1c, fail_st(1'b1), "status");
    rchk(8'h20, 32'h4, "error");
    w8(8'h24, 8'h17);
    log_try(good());
    sector();
    rchk(8'h1c, fail_st(1'b0), "status");
    rchk(8'h20, 32'h10, "error");
    $display("log abort test done");
    w8(8'h24, 8'h07);
    for (i = 0; i < 2; i++) begin
      // Second pass is the shared long period corner
      c = i ? 8'hf1 : 8'(60 + $urandom % 196);
      per = stby_cycles(c);
      w8(8'h04, c);
      cmd(8'he2);
      chk("standby", 32'(STANDBY_MODE), 32'h1);
      log_try(good());
      t0 = cyc;
      chk("standby", 32'(STANDBY_MODE), 32'h0);
      sector();
      while (!STANDBY_MODE && cyc - t0 < per + 20) @(posedge SYS_CLK);
      chk("expiry time", 32'(cyc - t0 <= per + 2 && cyc - t0 >= per - 12), 32'h1);
    end
    $display("standby timer test done");
    complete_run();
  end
endmodule
`default_nettype wire
